/* hdl/ubs_pkg.sv */
// Package: register map, field layout and reset values for the UART bank-select block
// Assumes: 32-bit Avalon-MM word addressing by byte address, one register per aligned word
package ubs_pkg;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [5:0] OFS_MSR_BANK  = 6'h00; // Read: modem status, write: bank select
   localparam logic [5:0] OFS_SCRATCH   = 6'h04;
   localparam logic [5:0] OFS_DIV_LOW   = 6'h08;
   localparam logic [5:0] OFS_DIV_HIGH  = 6'h0C;
   localparam logic [5:0] OFS_TX_SPACE  = 6'h10; // Counter slot, set 0 with access on
   localparam logic [5:0] OFS_RX_FILL   = 6'h14;
   localparam logic [5:0] OFS_EFC       = 6'h18;
   localparam logic [5:0] OFS_MODEM_CTL = 6'h1C;
   localparam logic [5:0] OFS_TRIG_LVL  = 6'h20;
   localparam logic [5:0] OFS_IRQ_STAT  = 6'h24;
   localparam logic [5:0] OFS_IRQ_EN    = 6'h28;
   localparam logic [5:0] OFS_IRQ_CLR   = 6'h2C;
   localparam logic [5:0] OFS_EXT1      = 6'h30; // Extra set 1 scratch word offset, unused; the word sits at the counter slot
   localparam logic [5:0] OFS_EXT2      = 6'h34;

   // ----------------------------------------------------------------
   // Fields
   // ----------------------------------------------------------------
   localparam int BSC_CNT_BIT   = 0;
   localparam int BSC_BANK_LSB  = 1;
   localparam int EFC_SWFC_MSB  = 4;
   localparam int EFC_RTS_BIT   = 6;
   localparam int EFC_CTS_BIT   = 7;
   localparam int MCTL_RTS_BIT  = 1;
   localparam int IRQ_TRIG_BIT  = 0;
   localparam int IRQ_MODEM_BIT = 1;
   localparam int IRQ_W         = 2;

   typedef enum logic [1:0] {UBS_BANK_GEN, UBS_BANK_EXT1, UBS_BANK_EXT2, UBS_BANK_RSVD} ubs_bank_t;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_BYTE      = 8'h00;
   localparam logic [7:0] RST_TRIG      = 8'h20;
   localparam logic [7:0] TRIG_STEP     = 8'h10; // Distance to next trigger level
   localparam logic [31:0] RD_UNMAPPED  = 32'h0000_0000;

endpackage : ubs_pkg

/* hdl/ubs_bank_ctrl.sv */
// Module: register bank select, divisor, scratch, enhanced features and auto RTS/CTS
// Assumes: Avalon-MM slave on mclk_i, FIFO levels and modem inputs synchronous to mclk_i
//
// Contract
// - Bank-select register is write-only; selects counters and extra feature sets.
// - Bits 2:1 select set: 00 general, 01 extra one, 10 extra two, 11 reserved.
// - Bit 0 set enables reading the transmit-space and receive-fill counters.
// - Bank field wins; counters readable only while bank field is zero.
// - Scratch register holds eight software bits with no effect on behaviour.
// - Divisor high and low bytes form a sixteen-bit divisor for baud generator.
// - Transmit counter is read-only and returns free transmit FIFO entries.
// - Receive counter is read-only and returns characters held in receive FIFO.
// - Enhanced bits 4:0 select single or dual character software flow control.
// - Enhanced bit 7 set: transmitter stops while clear-to-send high, resumes when low.
// - Auto clear-to-send throttling is disabled after reset.
// - Enhanced bit 6 set: interrupt when receive FIFO reaches trigger level.
// - Auto RTS drives request-to-send high at the next trigger level above programmed.
// - Auto RTS returns request-to-send low when fill drops below next lower level.
// - Without hardware flow control request-to-send follows the software modem bit.
// - Auto request-to-send throttling is disabled after reset.
// - Bank-select shares modem status address: reads give status, writes go to bank.
//
// The register addresses and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ns
module ubs_bank_ctrl
   import ubs_pkg::*;
#(
   parameter int LVL_W = 8                               // Width of FIFO level inputs
)(
   input  wire  logic                 mclk_i,           // System clock, 10 MHz
   input  wire  logic                 rst_i,            // Async reset, active high
   input  wire  logic [5:0]           avs_address_i,    // Byte address
   input  wire  logic                 avs_read_i,       // Read request
   input  wire  logic                 avs_write_i,      // Write request
   input  wire  logic [3:0]           avs_byteenable_i, // Byte enables
   input  wire  logic [31:0]          avs_writedata_i,  // Write data
   output logic       [31:0]          avs_readdata_o,   // Read data
   output logic                       avs_waitrequest_o,// Stall
   input  wire  logic [LVL_W-1:0]     tx_space_i,       // Free transmit FIFO entries
   input  wire  logic [LVL_W-1:0]     rx_fill_i,        // Receive FIFO fill
   input  wire  logic [7:0]           modem_status_i,   // Modem status byte from modem logic
   input  wire  logic                 cts_i,            // Clear-to-send, high means stop
   output logic                       tx_allow_o,       // Transmitter may send
   output logic                       rts_o,            // Request-to-send output
   output logic [15:0]                baud_div_o,       // Baud divisor
   output logic [1:0]                 bank_sel_o,       // Active register set
   output logic [3:0]                 swfc_mode_o,      // Software flow control mode
   output logic                       swfc_dual_o,      // Dual character mode
   output logic                       irq_o             // Level interrupt
);

   if (LVL_W < 1 || LVL_W > 8)
   begin : g_lvl_chk
      $error("LVL_W must be 1 to 8");
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [2:0]        bsc_r;
   logic [7:0]        scratch_r;
   logic [7:0]        div_lo_r;
   logic [7:0]        div_hi_r;
   logic [7:0]        efc_r;
   logic [7:0]        mctl_r;
   logic [7:0]        trig_r;
   logic [7:0]        ext1_r;
   logic [7:0]        ext2_r;
   logic [IRQ_W-1:0]  irq_stat_r;
   logic [IRQ_W-1:0]  irq_en_r;
   logic              ack_r;
   logic              trig_hit_d_r;
   logic [3:0]        modem_d_r;
   logic              auto_rts_r;

   logic              wr_stb;
   logic              wr_ok;
   logic              rd_stb;
   logic [7:0]        wbyte;
   logic              cnt_visible;
   logic [31:0]       rd_nxt;
   logic [7:0]        rx_fill8;
   logic [7:0]        tx_space8;
   logic              trig_hit;
   logic [IRQ_W-1:0]  irq_ev;

   function automatic logic [31:0] zx8(input logic [7:0] b);
      zx8 = {24'h00_0000, b};
   endfunction : zx8

   function automatic logic in_bank(input logic [2:0] bsc, input ubs_bank_t b);
      in_bank = (bsc[2:1] == b);
   endfunction : in_bank

   // Writes land on the edge at which waitrequest is seen low; reads sample one edge earlier
   assign wr_stb      = avs_write_i && ack_r;
   assign wr_ok       = wr_stb && avs_byteenable_i[0];
   assign rd_stb      = avs_read_i && !ack_r;
   assign wbyte       = avs_byteenable_i[0] ? avs_writedata_i[7:0] : 8'h00;
   assign cnt_visible = bsc_r[BSC_CNT_BIT] && in_bank(bsc_r, UBS_BANK_GEN);
   assign rx_fill8    = 8'(rx_fill_i);
   assign tx_space8   = 8'(tx_space_i);
   assign trig_hit    = rx_fill8 >= trig_r;

   // ----------------------------------------------------------------
   // Bus handshake: one wait cycle, answer on second edge
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         ack_r <= 1'b0;
      else
         ack_r <= (avs_read_i || avs_write_i) && !ack_r;
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         avs_waitrequest_o <= 1'b1;
      else
         avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !ack_r);
   end

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         bsc_r <= 3'h0;
      else if (wr_ok && avs_address_i == OFS_MSR_BANK)
         bsc_r <= wbyte[2:0];
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         scratch_r <= RST_BYTE;
      else if (wr_ok && avs_address_i == OFS_SCRATCH)
         scratch_r <= wbyte;
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         div_lo_r <= RST_BYTE;
      else if (wr_ok && avs_address_i == OFS_DIV_LOW)
         div_lo_r <= wbyte;
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         div_hi_r <= RST_BYTE;
      else if (wr_ok && avs_address_i == OFS_DIV_HIGH)
         div_hi_r <= wbyte;
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         efc_r <= RST_BYTE;
      else if (wr_ok && avs_address_i == OFS_EFC)
         efc_r <= wbyte;
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         mctl_r <= RST_BYTE;
      else if (wr_ok && avs_address_i == OFS_MODEM_CTL)
         mctl_r <= wbyte;
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         trig_r <= RST_TRIG;
      else if (wr_ok && avs_address_i == OFS_TRIG_LVL)
         trig_r <= wbyte;
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         irq_en_r <= '0;
      else if (wr_ok && avs_address_i == OFS_IRQ_EN)
         irq_en_r <= wbyte[IRQ_W-1:0];
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         ext1_r <= RST_BYTE;
      else if (wr_ok && avs_address_i == OFS_TX_SPACE && in_bank(bsc_r, UBS_BANK_EXT1))
         ext1_r <= wbyte;
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         ext2_r <= RST_BYTE;
      else if (wr_ok && avs_address_i == OFS_RX_FILL && in_bank(bsc_r, UBS_BANK_EXT2))
         ext2_r <= wbyte;
   end

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   always_comb
   begin
      rd_nxt = RD_UNMAPPED;
      case (avs_address_i)
         OFS_MSR_BANK:  rd_nxt = zx8(modem_status_i);
         OFS_SCRATCH:   rd_nxt = zx8(scratch_r);
         OFS_DIV_LOW:   rd_nxt = zx8(div_lo_r);
         OFS_DIV_HIGH:  rd_nxt = zx8(div_hi_r);
         OFS_EFC:       rd_nxt = zx8(efc_r);
         OFS_MODEM_CTL: rd_nxt = zx8(mctl_r);
         OFS_TRIG_LVL:  rd_nxt = zx8(trig_r);
         OFS_IRQ_STAT:  rd_nxt = zx8({6'h00, irq_stat_r});
         OFS_IRQ_EN:    rd_nxt = zx8({6'h00, irq_en_r});
         OFS_TX_SPACE:
            if (cnt_visible)
               rd_nxt = zx8(tx_space8);
            else if (in_bank(bsc_r, UBS_BANK_EXT1))
               rd_nxt = zx8(ext1_r);
            else
               rd_nxt = RD_UNMAPPED;
         OFS_RX_FILL:
            if (cnt_visible)
               rd_nxt = zx8(rx_fill8);
            else if (in_bank(bsc_r, UBS_BANK_EXT2))
               rd_nxt = zx8(ext2_r);
            else
               rd_nxt = RD_UNMAPPED;
         default:       rd_nxt = RD_UNMAPPED;
      endcase
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         avs_readdata_o <= RD_UNMAPPED;
      else if (rd_stb)
         avs_readdata_o <= rd_nxt;
   end

   // ----------------------------------------------------------------
   // Interrupt events: trigger reached, modem status change flag
   // ----------------------------------------------------------------
   assign irq_ev[IRQ_TRIG_BIT]  = efc_r[EFC_RTS_BIT] && trig_hit && !trig_hit_d_r;
   assign irq_ev[IRQ_MODEM_BIT] = |(modem_status_i[3:0] & ~modem_d_r[3:0]);

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         trig_hit_d_r <= 1'b0;
         modem_d_r    <= 4'h0;
      end
      else
      begin
         trig_hit_d_r <= trig_hit;
         modem_d_r    <= modem_status_i[3:0];
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         irq_stat_r <= '0;
      else if (wr_ok && avs_address_i == OFS_IRQ_CLR)
         irq_stat_r <= (irq_stat_r & ~wbyte[IRQ_W-1:0]) | irq_ev;
      else
         irq_stat_r <= irq_stat_r | irq_ev;
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         irq_o <= 1'b0;
      else
         irq_o <= |(irq_stat_r & irq_en_r);
   end

   // ----------------------------------------------------------------
   // Auto RTS hysteresis
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         auto_rts_r <= 1'b0;
      else if (!efc_r[EFC_RTS_BIT])
         auto_rts_r <= 1'b0;
      else if (9'(rx_fill8) >= 9'(trig_r) + 9'(TRIG_STEP))
         auto_rts_r <= 1'b1;
      else if (9'(rx_fill8) + 9'(TRIG_STEP) < 9'(trig_r))
         auto_rts_r <= 1'b0;
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         rts_o <= 1'b0;
      else if (efc_r[EFC_RTS_BIT])
         rts_o <= auto_rts_r;
      else
         rts_o <= mctl_r[MCTL_RTS_BIT];
   end

   // ----------------------------------------------------------------
   // Transmit throttle and configuration outputs
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         tx_allow_o <= 1'b1;
      else
         tx_allow_o <= !(efc_r[EFC_CTS_BIT] && cts_i);
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         baud_div_o <= 16'h0000;
      else
         baud_div_o <= {div_hi_r, div_lo_r};
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         bank_sel_o <= 2'h0;
      else
         bank_sel_o <= bsc_r[2:1];
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         swfc_mode_o <= 4'h0;
      else
         swfc_mode_o <= efc_r[3:0];
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         swfc_dual_o <= 1'b0;
      else
         swfc_dual_o <= efc_r[EFC_SWFC_MSB] && (&efc_r[3:2] || &efc_r[1:0]);
   end

endmodule : ubs_bank_ctrl

/* bench/ubs_bank_ctrl_assertions.sv */
// Checker: bus answer and flow-control properties of ubs_bank_ctrl
// Assumes: bound to ubs_bank_ctrl, one clock mclk_i, async reset rst_i
`timescale 1ns/1ns
module ubs_bank_ctrl_assertions
   import ubs_pkg::*;
#(
   parameter int LVL_W = 8                   // Level width
)(
   input wire logic             mclk_i,            // Clock
   input wire logic             rst_i,             // Reset
   input wire logic [5:0]       avs_address_i,     // Address
   input wire logic             avs_read_i,        // Read
   input wire logic             avs_write_i,       // Write
   input wire logic [3:0]       avs_byteenable_i,  // Enables
   input wire logic [31:0]      avs_writedata_i,   // Write data
   input wire logic [31:0]      avs_readdata_o,    // Read data
   input wire logic             avs_waitrequest_o, // Stall
   input wire logic [LVL_W-1:0] tx_space_i,        // Tx space
   input wire logic [LVL_W-1:0] rx_fill_i,         // Rx fill
   input wire logic [7:0]       modem_status_i,    // Status
   input wire logic             cts_i,             // Stop
   input wire logic             tx_allow_o,        // Tx allowed
   input wire logic             rts_o,             // RTS
   input wire logic [15:0]      baud_div_o,        // Divisor
   input wire logic [1:0]       bank_sel_o,        // Set
   input wire logic [3:0]       swfc_mode_o,       // Mode
   input wire logic             swfc_dual_o,       // Dual
   input wire logic             irq_o              // Interrupt
);
   logic [2:0] bsc_r;
   logic [7:0] efc_r;
   logic [7:0] trig_r;
   logic       srts_r;
   logic       wack;
   logic       rack;
   assign wack = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
   assign rack = avs_read_i && !avs_waitrequest_o;
   // ----------------------------------------------------------------
   // Shadow of the registers written by software
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         bsc_r  <= 3'h0;
         efc_r  <= 8'h00;
         trig_r <= RST_TRIG;
         srts_r <= 1'b0;
      end
      else if (wack)
      begin
         if (avs_address_i == OFS_MSR_BANK) bsc_r <= avs_writedata_i[2:0];
         if (avs_address_i == OFS_EFC) efc_r <= avs_writedata_i[7:0];
         if (avs_address_i == OFS_TRIG_LVL) trig_r <= avs_writedata_i[7:0];
         if (avs_address_i == OFS_MODEM_CTL) srts_r <= avs_writedata_i[MCTL_RTS_BIT];
      end
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   AST_WAIT_ANS: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("no answer one cycle after request");
   AST_WAIT_ONE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low too long");
   AST_MSR: assert property (rack && avs_address_i == OFS_MSR_BANK |->
      avs_readdata_o == {24'h0, $past(modem_status_i)}) else $error("status read wrong");
   AST_TXCNT: assert property (rack && avs_address_i == OFS_TX_SPACE && bsc_r == 3'h1 |->
      avs_readdata_o == 32'($past(tx_space_i))) else $error("tx space read wrong");
   AST_RXCNT: assert property (rack && avs_address_i == OFS_RX_FILL && bsc_r == 3'h1 |->
      avs_readdata_o == 32'($past(rx_fill_i))) else $error("rx fill read wrong");
   AST_NOCNT: assert property (rack && avs_address_i == OFS_TX_SPACE && bsc_r == 3'h0 |->
      avs_readdata_o == 32'h0) else $error("counter readable while off");
   AST_CTS_STOP: assert property (efc_r[EFC_CTS_BIT] && cts_i |=> !tx_allow_o)
      else $error("tx not stopped");
   AST_CTS_GO: assert property (!(efc_r[EFC_CTS_BIT] && cts_i) |=> tx_allow_o)
      else $error("tx stopped wrongly");
   AST_RTS_HI: assert property (efc_r[EFC_RTS_BIT] && 9'(rx_fill_i) >= 9'(trig_r) + 9'(TRIG_STEP)
      ##1 efc_r[EFC_RTS_BIT] |=> rts_o) else $error("rts not raised");
   AST_RTS_LO: assert property (efc_r[EFC_RTS_BIT] && 9'(rx_fill_i) + 9'(TRIG_STEP) < 9'(trig_r)
      ##1 efc_r[EFC_RTS_BIT] |=> !rts_o) else $error("rts not lowered");
   AST_RTS_SW: assert property (!efc_r[EFC_RTS_BIT] |=> rts_o == $past(srts_r))
      else $error("rts not software driven");
endmodule : ubs_bank_ctrl_assertions
bind ubs_bank_ctrl ubs_bank_ctrl_assertions #(.LVL_W(LVL_W)) u_chk (.mclk_i(mclk_i), .rst_i(rst_i),
   .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
   .avs_byteenable_i(avs_byteenable_i), .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o), .tx_space_i(tx_space_i), .rx_fill_i(rx_fill_i),
   .modem_status_i(modem_status_i), .cts_i(cts_i), .tx_allow_o(tx_allow_o), .rts_o(rts_o),
   .baud_div_o(baud_div_o), .bank_sel_o(bank_sel_o), .swfc_mode_o(swfc_mode_o), .swfc_dual_o(swfc_dual_o),
   .irq_o(irq_o));

/* bench/ubs_modem_model.sv */
// Model: remote modem and FIFO side, presents levels one clock after request
// Assumes: bench sets the wanted levels, mclk_i shared with the block
`timescale 1ns/1ns
module ubs_modem_model (
   input  wire logic       mclk_i,   // Clock
   input  wire logic       stop_i,   // Wanted CTS level
   input  wire logic [7:0] stat_i,   // Wanted status
   input  wire logic [7:0] space_i,  // Wanted tx space
   input  wire logic [7:0] fill_i,   // Wanted rx fill
   output logic            cts_o = 1'b0,     // CTS, high stops
   output logic [7:0]      stat_o = 8'h00,   // Status
   output logic [7:0]      space_o = 8'h00,  // Tx space
   output logic [7:0]      fill_o = 8'h00    // Rx fill
);
   always @(posedge mclk_i)
   begin
      cts_o   <= stop_i;
      stat_o  <= stat_i;
      space_o <= space_i;
      fill_o  <= fill_i;
   end
endmodule : ubs_modem_model

/* bench/ubs_bank_ctrl_bench.sv */
// Testbench: register, counter, flow-control and interrupt tests over Avalon-MM
// Assumes: ubs_bank_ctrl with default level width, modem model on far side
`timescale 1ns/1ns
module ubs_bank_ctrl_bench;
   import ubs_pkg::*;
   logic mclk_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o, cts_i, tx_allow_o, rts_o, swfc_dual_o, irq_o;
   logic [5:0] avs_address_i;
   logic [3:0] avs_byteenable_i, swfc_mode_o;
   logic [31:0] avs_writedata_i, avs_readdata_o;
   logic [7:0] tx_space_i, rx_fill_i, modem_status_i, stat, space, fill, v;
   logic [15:0] baud_div_o;
   logic [1:0] bank_sel_o;
   logic stop;
   int fails = 0, num_checks = 0, test = 0;
   logic [7:0] v_tab [4] = '{8'h1C, 8'h1A, 8'h0F, 8'h13};
   logic       d_tab [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
   ubs_bank_ctrl uut (.mclk_i(mclk_i), .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
      .avs_write_i(avs_write_i), .avs_byteenable_i(avs_byteenable_i), .avs_writedata_i(avs_writedata_i),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .tx_space_i(tx_space_i),
      .rx_fill_i(rx_fill_i), .modem_status_i(modem_status_i), .cts_i(cts_i), .tx_allow_o(tx_allow_o),
      .rts_o(rts_o), .baud_div_o(baud_div_o), .bank_sel_o(bank_sel_o), .swfc_mode_o(swfc_mode_o),
      .swfc_dual_o(swfc_dual_o), .irq_o(irq_o));
   ubs_modem_model model (.mclk_i(mclk_i), .stop_i(stop), .stat_i(stat), .space_i(space), .fill_i(fill),
      .cts_o(cts_i), .stat_o(modem_status_i), .space_o(tx_space_i), .fill_o(rx_fill_i));
   initial
   begin
      mclk_i = 1'b0;
      forever #50 mclk_i = ~mclk_i;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic acc(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge mclk_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= wr;
      avs_read_i <= !wr;
      do
      begin
         @(posedge mclk_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0 && n < 50);
      q = avs_readdata_o;
      if (n >= 50)
      begin
         fails++;
         tally_and_finish;
      end
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
   endtask : acc
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] q;
      acc(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [5:0] a, input logic [31:0] e);
      logic [31:0] q;
      acc(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask : rd
   task automatic w4;
      repeat (4) @(posedge mclk_i);
   endtask : w4
   task automatic done;
      test++;
      $display("test %0d ended", test);
   endtask : done
   task automatic tally_and_finish;
      $display("checks %0d, mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : tally_and_finish
   initial
   begin
      #2000000;
      fails++;
      tally_and_finish;
   end
   initial
   begin
      rst_i = 1'b1;
      {avs_read_i, avs_write_i, stop} = 3'b000;
      avs_address_i = 6'h00;
      avs_byteenable_i = 4'hF;
      avs_writedata_i = 32'h0;
      {stat, space, fill} = 24'h0;
      repeat (4) @(posedge mclk_i);
      rst_i <= 1'b0;
      w4;
      chk(32'(tx_allow_o), 32'h1);
      chk(32'(rts_o), 32'h0);
      rd(OFS_EFC, 32'h0);
      rd(OFS_TRIG_LVL, 32'(RST_TRIG));
      done;
      wr(OFS_DIV_LOW, 32'h34);
      wr(OFS_DIV_HIGH, 32'h12);
      wr(OFS_SCRATCH, 32'hA5);
      w4;
      chk(32'(baud_div_o), 32'h1234);
      rd(OFS_SCRATCH, 32'hA5);
      rd(OFS_DIV_HIGH, 32'h12);
      avs_byteenable_i <= 4'h0;
      wr(OFS_SCRATCH, 32'h5A);
      avs_byteenable_i <= 4'hF;
      wr(6'h3C, 32'hFF);
      rd(OFS_SCRATCH, 32'hA5);
      rd(6'h3C, RD_UNMAPPED);
      done;
      stat <= 8'h96;
      space <= 8'h3C;
      fill <= 8'h11;
      for (int i = 0; i < 4; i++)
      begin
         wr(OFS_MSR_BANK, 32'(i * 2));
         w4;
         chk(32'(bank_sel_o), 32'(i));
      end
      rd(OFS_MSR_BANK, 32'h96);
      wr(OFS_MSR_BANK, 32'h1);
      rd(OFS_TX_SPACE, 32'h3C);
      rd(OFS_RX_FILL, 32'h11);
      wr(OFS_MSR_BANK, 32'h0);
      rd(OFS_TX_SPACE, 32'h0);
      wr(OFS_MSR_BANK, 32'h3);
      rd(OFS_RX_FILL, 32'h0);
      wr(OFS_TX_SPACE, 32'h5C);
      rd(OFS_TX_SPACE, 32'h5C);
      wr(OFS_MSR_BANK, 32'h5);
      rd(OFS_TX_SPACE, 32'h0);
      wr(OFS_RX_FILL, 32'hC5);
      rd(OFS_RX_FILL, 32'hC5);
      wr(OFS_MSR_BANK, 32'h0);
      done;
      foreach (v_tab[i])
      begin
         v = v_tab[i];
         wr(OFS_EFC, 32'(v));
         w4;
         chk(32'(swfc_mode_o), 32'(v[3:0]));
         chk(32'(swfc_dual_o), 32'(d_tab[i]));
         rd(OFS_EFC, 32'(v));
      end
      done;
      wr(OFS_EFC, 32'h80);
      stop <= 1'b1;
      w4;
      chk(32'(tx_allow_o), 32'h0);
      stop <= 1'b0;
      w4;
      chk(32'(tx_allow_o), 32'h1);
      stop <= 1'b1;
      wr(OFS_EFC, 32'h0);
      w4;
      chk(32'(tx_allow_o), 32'h1);
      stop <= 1'b0;
      done;
      wr(OFS_MODEM_CTL, 32'h2);
      w4;
      chk(32'(rts_o), 32'h1);
      wr(OFS_MODEM_CTL, 32'h0);
      w4;
      chk(32'(rts_o), 32'h0);
      wr(OFS_IRQ_CLR, 32'h3);
      wr(OFS_IRQ_EN, 32'h1);
      wr(OFS_EFC, 32'h40);
      fill <= 8'h20;
      w4;
      chk(32'(irq_o), 32'h1);
      chk(32'(rts_o), 32'h0);
      fill <= 8'h30;
      w4;
      chk(32'(rts_o), 32'h1);
      fill <= 8'h18;
      w4;
      chk(32'(rts_o), 32'h1);
      fill <= 8'h0F;
      w4;
      chk(32'(rts_o), 32'h0);
      wr(OFS_IRQ_CLR, 32'h1);
      w4;
      chk(32'(irq_o), 32'h0);
      rd(OFS_IRQ_STAT, 32'h0);
      wr(OFS_IRQ_EN, 32'h0);
      fill <= 8'h20;
      w4;
      chk(32'(irq_o), 32'h0);
      wr(OFS_IRQ_EN, 32'h1);
      w4;
      chk(32'(irq_o), 32'h1);
      stat <= 8'h9F;
      w4;
      rd(OFS_IRQ_STAT, 32'h3);
      rd(OFS_MSR_BANK, 32'h9F);
      done;
      tally_and_finish;
   end
endmodule : ubs_bank_ctrl_bench
